/* inc/ffmd_pkg.sv */
package ffmd_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] FFMD_OFS_CFG    = 8'h15;
	localparam logic [7:0] FFMD_OFS_SRC    = 8'h16;
	localparam logic [7:0] FFMD_OFS_THS    = 8'h17;
	localparam logic [7:0] FFMD_OFS_COUNT  = 8'h18;
	localparam logic [7:0] FFMD_OFS_IRQCTL = 8'h19;
	localparam logic [7:0] FFMD_OFS_STAT   = 8'h1A;
	// register field positions
	localparam int FFMD_CFG_LATCH   = 7;
	localparam int FFMD_CFG_COMBINE = 6;
	localparam int FFMD_CFG_ZEN     = 5;
	localparam int FFMD_CFG_YEN     = 4;
	localparam int FFMD_CFG_XEN     = 3;
	localparam int FFMD_THS_DBMODE  = 7;
	localparam int FFMD_SRC_ACTIVE  = 7;
	localparam int FFMD_IRQ_ENABLE  = 0;
	localparam int FFMD_IRQ_ROUTE   = 1;
	localparam int FFMD_IRQ_LOWNOISE = 2;
	// reset values
	localparam logic [7:0] FFMD_CFG_RESET   = 8'h00;
	localparam logic [7:0] FFMD_THS_RESET   = 8'h00;
	localparam logic [7:0] FFMD_COUNT_RESET = 8'h00;
	localparam logic [2:0] FFMD_IRQ_RESET   = 3'h0;
	localparam logic [7:0] FFMD_ZERO8       = 8'h00;
	// 0.063 g per threshold step: 4 g is code 63
	localparam logic [6:0] FFMD_THS_LOWNOISE_MAX = 7'h3F;
	localparam int FFMD_AXES = 3;
	localparam int FFMD_ACC_W = 10;

	typedef struct packed {
		logic latch;
		logic combine;
		logic [2:0] axis_en;   // z, y, x
	} ffmd_cfg_type;

	typedef struct packed {
		logic active;
		logic [2:0] event_f;   // z, y, x
		logic [2:0] polarity;  // z, y, x
	} ffmd_flags_type;
endpackage : ffmd_pkg

/* rtl/ffmd_axis_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
// one axis: magnitude against threshold, with sign for polarity
module ffmd_axis_cmp
	import ffmd_pkg::*;
(
	input  wire logic signed [FFMD_ACC_W-1:0] accel_in,
	input  wire logic [6:0]                   threshold_in,
	output logic                              high_out,
	output logic                              low_out,
	output logic                              negative_out
);
	logic [FFMD_ACC_W-1:0] magnitude;
	logic [6:0]            scaled;

	always_comb begin
		magnitude = accel_in[FFMD_ACC_W-1] ?
			FFMD_ACC_W'(-accel_in) : FFMD_ACC_W'(accel_in);
		// samples carry 3 extra bits below the 0.063 g step
		scaled = (magnitude[FFMD_ACC_W-1:3] > 7'h7F) ? 7'h7F :
			magnitude[9:3];
	end

	always_comb begin
		high_out = scaled > threshold_in;
		low_out  = scaled <= threshold_in;
		negative_out = accel_in[FFMD_ACC_W-1];
	end
endmodule // ffmd_axis_cmp
`default_nettype wire

/* rtl/ffmd_debounce.sv */
`timescale 1ns/1ns
`default_nettype none
module ffmd_debounce
	import ffmd_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       sample_in,
	input  wire logic       cond_in,
	input  wire logic       mode_in,
	input  wire logic [7:0] limit_in,
	input  wire logic       clear_in,
	output logic            done_out,
	output logic [7:0]      count_out
);
	logic [7:0] count_reg;
	logic [7:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clear_in) begin
			count_next = FFMD_ZERO8;
		end else if (sample_in) begin
			if (cond_in) begin
				if (count_reg < limit_in) begin
					count_next = count_reg + 8'h01;
				end else begin
					count_next = limit_in;
				end
			end else if (mode_in) begin
				count_next = FFMD_ZERO8;
			end else if (count_reg != FFMD_ZERO8) begin
				count_next = count_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_reg <= FFMD_ZERO8;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count_out = count_reg;
	// mode 0 holds the event until the counter drops below the limit
	assign done_out = (count_reg >= limit_in) &&
		(cond_in || !mode_in) && (count_reg != FFMD_ZERO8 ||
		limit_in == FFMD_ZERO8 && cond_in);

	a_count_bound: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) count_reg <= limit_in || $changed(limit_in)
		|| $past(count_reg) > limit_in)
		else $error("debounce counter above limit");
	a_clear_mode: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) sample_in && !cond_in && mode_in
		|=> count_reg == FFMD_ZERO8)
		else $error("counter not cleared in mode 1");
	a_drop_one: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) sample_in && !cond_in && !mode_in
		&& !clear_in && count_reg != FFMD_ZERO8
		|=> count_reg == $past(count_reg) - 8'h01)
		else $error("counter did not drop by one");
endmodule // ffmd_debounce
`default_nettype wire

/* rtl/ffmd_detector.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module ffmd_detector
	import ffmd_pkg::*;
(
	input  wire logic                        sys_clk_in,
	input  wire logic                        resetn_in,
	input  wire logic [7:0]                  addr_in,
	input  wire logic [7:0]                  wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	input  wire logic                        sample_valid_in,
	input  wire logic signed [FFMD_ACC_W-1:0] x_accel_in,
	input  wire logic signed [FFMD_ACC_W-1:0] y_accel_in,
	input  wire logic signed [FFMD_ACC_W-1:0] z_accel_in,
	output logic [7:0]                       rdata_out,
	output logic                             irq_pin1_out,
	output logic                             irq_pin2_out,
	output logic                             event_active_out
);
	ffmd_cfg_type   cfg_reg;
	ffmd_flags_type flags_reg;
	ffmd_flags_type flags_next;
	logic [7:0] ths_reg;
	logic [7:0] count_lim_reg;
	logic [2:0] irqctl_reg;
	logic [7:0] rdata_reg;
	logic       irq1_reg;
	logic       irq2_reg;
	logic       src_read;
	logic [6:0] threshold_eff;
	logic [2:0] high_v;
	logic [2:0] low_v;
	logic [2:0] neg_v;
	logic [2:0] hit_v;
	logic       combined;
	logic       deb_done;
	logic [7:0] deb_count;
	logic signed [FFMD_ACC_W-1:0] accel_v [FFMD_AXES];

	assign src_read = rd_in && addr_in == FFMD_OFS_SRC;
	assign accel_v[0] = x_accel_in;
	assign accel_v[1] = y_accel_in;
	assign accel_v[2] = z_accel_in;

	// low-noise mode only reaches 4 g whatever the full scale
	assign threshold_eff = (irqctl_reg[FFMD_IRQ_LOWNOISE] &&
		ths_reg[6:0] > FFMD_THS_LOWNOISE_MAX) ?
		FFMD_THS_LOWNOISE_MAX : ths_reg[6:0];

	for (genvar i = 0; i < FFMD_AXES; i++) begin : g_axis
		ffmd_axis_cmp u_cmp (
			.accel_in    (accel_v[i]),
			.threshold_in(threshold_eff),
			.high_out    (high_v[i]),
			.low_out     (low_v[i]),
			.negative_out(neg_v[i])
		);
		// axis_en is packed z, y, x so bit i already names axis i
		assign hit_v[i] = cfg_reg.axis_en[i] && high_v[i];
	end

	// freefall needs every enabled axis low; none enabled disables it
	always_comb begin
		if (cfg_reg.combine) begin
			combined = |hit_v;
		end else begin
			combined = (cfg_reg.axis_en != 3'h0) &&
				&(low_v | ~cfg_reg.axis_en);
		end
	end

	ffmd_debounce u_deb (
		.sys_clk_in(sys_clk_in),
		.resetn_in (resetn_in),
		.sample_in (sample_valid_in),
		.cond_in   (combined),
		.mode_in   (ths_reg[FFMD_THS_DBMODE]),
		.limit_in  (count_lim_reg),
		.clear_in  (src_read && cfg_reg.latch),
		.done_out  (deb_done),
		.count_out (deb_count)
	);

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_reg       <= ffmd_cfg_type'(5'h00);
			ths_reg       <= FFMD_THS_RESET;
			count_lim_reg <= FFMD_COUNT_RESET;
			irqctl_reg    <= FFMD_IRQ_RESET;
		end else if (wr_in) begin
			unique case (addr_in)
				FFMD_OFS_CFG: begin
					cfg_reg <= wdata_in[7:3];
				end
				FFMD_OFS_THS: begin
					ths_reg <= wdata_in;
				end
				FFMD_OFS_COUNT: begin
					count_lim_reg <= wdata_in;
				end
				FFMD_OFS_IRQCTL: begin
					irqctl_reg <= wdata_in[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		flags_next = flags_reg;
		if (cfg_reg.latch) begin
			// a fresh detection in the read cycle loads the axis flags but leaves active clear
			if (src_read) begin
				flags_next = ffmd_flags_type'(7'h00);
			end
			if (!flags_reg.active || src_read) begin
				flags_next.event_f  = {hit_v[2], hit_v[1], hit_v[0]};
				flags_next.polarity = {hit_v[2] & neg_v[2],
					hit_v[1] & neg_v[1], hit_v[0] & neg_v[0]};
				flags_next.active = deb_done && !src_read;
			end
		end else begin
			flags_next.event_f  = {hit_v[2], hit_v[1], hit_v[0]};
			flags_next.polarity = {hit_v[2] & neg_v[2],
				hit_v[1] & neg_v[1], hit_v[0] & neg_v[0]};
			flags_next.active = deb_done;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_reg <= ffmd_flags_type'(7'h00);
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_reg <= FFMD_ZERO8;
		end else if (rd_in) begin
			unique case (addr_in)
				FFMD_OFS_CFG: begin
					rdata_reg <= {cfg_reg, 3'h0};
				end
				FFMD_OFS_SRC: begin
					rdata_reg <= {flags_reg.active, 1'b0,
						flags_reg.event_f[2], flags_reg.polarity[2],
						flags_reg.event_f[1], flags_reg.polarity[1],
						flags_reg.event_f[0], flags_reg.polarity[0]};
				end
				FFMD_OFS_THS: begin
					rdata_reg <= ths_reg;
				end
				FFMD_OFS_COUNT: begin
					rdata_reg <= count_lim_reg;
				end
				FFMD_OFS_IRQCTL: begin
					rdata_reg <= {5'h00, irqctl_reg};
				end
				FFMD_OFS_STAT: begin
					rdata_reg <= deb_count;
				end
				default: begin
					rdata_reg <= FFMD_ZERO8;
				end
			endcase
		end else begin
			rdata_reg <= FFMD_ZERO8;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq1_reg <= 1'b0;
			irq2_reg <= 1'b0;
		end else begin
			irq1_reg <= flags_next.active && irqctl_reg[FFMD_IRQ_ENABLE]
				&& irqctl_reg[FFMD_IRQ_ROUTE];
			irq2_reg <= flags_next.active && irqctl_reg[FFMD_IRQ_ENABLE]
				&& !irqctl_reg[FFMD_IRQ_ROUTE];
		end
	end

	assign rdata_out        = rdata_reg;
	assign irq_pin1_out     = irq1_reg;
	assign irq_pin2_out     = irq2_reg;
	assign event_active_out = flags_reg.active;

	sequence s_src_read_latched;
		rd_in && addr_in == FFMD_OFS_SRC && cfg_reg.latch;
	endsequence

	a_read_clears: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) s_src_read_latched |=> !flags_reg.active)
		else $error("latched read did not clear active");
	a_flags_frozen: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) cfg_reg.latch && flags_reg.active
		&& !src_read && !wr_in |=> $stable(flags_reg.event_f))
		else $error("latched flags moved");
	a_disabled_zero: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) !cfg_reg.latch && !$past(wr_in) |->
		(flags_reg.event_f & ~$past(cfg_reg.axis_en)) == 3'h0)
		else $error("disabled axis flag set");
	a_live_flags: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) !cfg_reg.latch && !wr_in |=>
		flags_reg.event_f == $past({hit_v[2], hit_v[1], hit_v[0]}))
		else $error("live flags stale");
	a_src_bit6: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) src_read |=> rdata_out[6] == 1'b0)
		else $error("source bit 6 not zero");
	a_irq_gate: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) !irqctl_reg[FFMD_IRQ_ENABLE] && !wr_in
		|=> !irq_pin1_out && !irq_pin2_out)
		else $error("irq without enable");
	a_ths_cap: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) irqctl_reg[FFMD_IRQ_LOWNOISE] |->
		threshold_eff <= FFMD_THS_LOWNOISE_MAX)
		else $error("low-noise threshold above cap");
	a_polarity_sign: assert property (@(posedge sys_clk_in)
		disable iff (!resetn_in) !cfg_reg.latch && !wr_in && hit_v[0]
		|=> flags_reg.polarity[0] == $past(x_accel_in[FFMD_ACC_W-1]))
		else $error("x polarity wrong");
endmodule // ffmd_detector
`default_nettype wire

/* verif/ffmd_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host processor model: one-cycle strobes, changed by nba after the edge
module ffmd_host (
	input  wire logic       sys_clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge sys_clk_in);
		wr_out <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge sys_clk_in);
		rd_out <= 1'b0;
		#1 d = rdata_in;
	endtask
endmodule // ffmd_host
`default_nettype wire

/* verif/test_ffmd_detector.sv */
`timescale 1ns/1ns
`default_nettype none
module test_ffmd_detector;
	import ffmd_pkg::*;
	typedef struct packed {
		logic [7:0] cfg;
		logic [9:0] x;
		logic [9:0] y;
		logic [9:0] z;
		logic [7:0] src;
	} ffmd_row_type;

	logic       sys_clk_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic       sample_valid_in = 1'b0;
	logic [9:0] x_a = 10'h000;
	logic [9:0] y_a = 10'h000;
	logic [9:0] z_a = 10'h000;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       pin1;
	logic       pin2;
	logic       active;
	int         fail_count = 0;
	int         n_compared = 0;
	// ths 10: magnitude code 10 (80) is low, 11 (88) is high
	ffmd_row_type rows [8] = '{
		'{8'h78, 10'h064, 10'h39c, 10'h008, 8'h8e},
		'{8'h68, 10'h064, 10'h064, 10'h008, 8'h82},
		'{8'h68, 10'h008, 10'h008, 10'h39c, 8'hb0},
		'{8'h38, 10'h008, 10'h008, 10'h000, 8'h80},
		'{8'h38, 10'h064, 10'h008, 10'h000, 8'h02},
		'{8'h48, 10'h050, 10'h000, 10'h000, 8'h00},
		'{8'h48, 10'h058, 10'h000, 10'h000, 8'h82},
		'{8'h08, 10'h050, 10'h000, 10'h000, 8'h80}};

	always #10 sys_clk_in = ~sys_clk_in;

	ffmd_host ffmd_host_i (.sys_clk_in(sys_clk_in), .rdata_in(rdata),
		.addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	ffmd_detector ffmd_detector_i (.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .sample_valid_in(sample_valid_in),
		.x_accel_in(x_a), .y_accel_in(y_a), .z_accel_in(z_a),
		.rdata_out(rdata), .irq_pin1_out(pin1), .irq_pin2_out(pin2),
		.event_active_out(active));

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		ffmd_host_i.rd_reg(a, d);
		chk(nm, e, d);
	endtask

	// accel inputs are held after the pulse; flags settle two edges later
	task automatic smp(input logic [9:0] x, input logic [9:0] y,
		input logic [9:0] z, input int n);
		repeat (n) begin
			@(posedge sys_clk_in);
			x_a <= x;
			y_a <= y;
			z_a <= z;
			sample_valid_in <= 1'b1;
			@(posedge sys_clk_in);
			sample_valid_in <= 1'b0;
			repeat (2) @(posedge sys_clk_in);
		end
		#1;
	endtask

	task automatic end_sim();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (8) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rchk("cfg", FFMD_OFS_CFG, 8'h00);
		rchk("src", FFMD_OFS_SRC, 8'h00);
		rchk("ths", FFMD_OFS_THS, 8'h00);
		rchk("count", FFMD_OFS_COUNT, 8'h00);
		rchk("unmapped", 8'h30, 8'h00);
		ffmd_host_i.wr_reg(FFMD_OFS_SRC, 8'hff);
		rchk("src ro", FFMD_OFS_SRC, 8'h00);
		ffmd_host_i.wr_reg(FFMD_OFS_CFG, 8'hff);
		rchk("cfg rw", FFMD_OFS_CFG, 8'hf8);
		ffmd_host_i.wr_reg(FFMD_OFS_COUNT, 8'ha5);
		rchk("count rw", FFMD_OFS_COUNT, 8'ha5);
		ffmd_host_i.wr_reg(FFMD_OFS_COUNT, 8'h00);
		ffmd_host_i.wr_reg(FFMD_OFS_THS, 8'h8a);
		rchk("ths rw", FFMD_OFS_THS, 8'h8a);
		foreach (rows[i]) begin
			ffmd_host_i.wr_reg(FFMD_OFS_CFG, rows[i].cfg);
			smp(rows[i].x, rows[i].y, rows[i].z, 1);
			rchk("row src", FFMD_OFS_SRC, rows[i].src);
		end
		// latched: flags frozen at the first event, cleared by the read
		ffmd_host_i.wr_reg(FFMD_OFS_CFG, 8'hc8);
		// the last row left active set: it stays frozen until read
		rchk("latch entry", FFMD_OFS_SRC, 8'h80);
		smp(10'h064, 10'h000, 10'h000, 1);
		chk("latched active", 8'h01, {7'h00, active});
		smp(10'h39c, 10'h000, 10'h000, 1);
		smp(10'h008, 10'h000, 10'h000, 1);
		chk("held active", 8'h01, {7'h00, active});
		rchk("frozen src", FFMD_OFS_SRC, 8'h82);
		rchk("cleared src", FFMD_OFS_SRC, 8'h00);
		chk("cleared active", 8'h00, {7'h00, active});
		// debounce: clear-on-false mode against decrement mode
		ffmd_host_i.wr_reg(FFMD_OFS_CFG, 8'h48);
		ffmd_host_i.wr_reg(FFMD_OFS_COUNT, 8'h03);
		smp(10'h064, 10'h000, 10'h000, 2);
		chk("two of three", 8'h00, {7'h00, active});
		smp(10'h064, 10'h000, 10'h000, 3);
		chk("count reached", 8'h01, {7'h00, active});
		rchk("counter cap", FFMD_OFS_STAT, 8'h03);
		smp(10'h008, 10'h000, 10'h000, 1);
		rchk("mode1 clear", FFMD_OFS_STAT, 8'h00);
		chk("mode1 active", 8'h00, {7'h00, active});
		ffmd_host_i.wr_reg(FFMD_OFS_THS, 8'h0a);
		smp(10'h064, 10'h000, 10'h000, 3);
		smp(10'h008, 10'h000, 10'h000, 1);
		rchk("mode0 dec", FFMD_OFS_STAT, 8'h02);
		smp(10'h064, 10'h000, 10'h000, 1);
		chk("mode0 resume", 8'h01, {7'h00, active});
		smp(10'h008, 10'h000, 10'h000, 4);
		rchk("mode0 floor", FFMD_OFS_STAT, 8'h00);
		// code 64 passes only the low-noise cap of 63
		ffmd_host_i.wr_reg(FFMD_OFS_COUNT, 8'h00);
		ffmd_host_i.wr_reg(FFMD_OFS_THS, 8'h7f);
		smp(10'h200, 10'h000, 10'h000, 1);
		rchk("full range", FFMD_OFS_SRC, 8'h00);
		ffmd_host_i.wr_reg(FFMD_OFS_IRQCTL, 8'h04);
		smp(10'h200, 10'h000, 10'h000, 1);
		rchk("low noise", FFMD_OFS_SRC, 8'h83);
		chk("irq off", 8'h00, {6'h00, pin1, pin2});
		ffmd_host_i.wr_reg(FFMD_OFS_IRQCTL, 8'h05);
		repeat (2) @(posedge sys_clk_in);
		#1 chk("irq pin2", 8'h01, {6'h00, pin1, pin2});
		ffmd_host_i.wr_reg(FFMD_OFS_IRQCTL, 8'h07);
		repeat (2) @(posedge sys_clk_in);
		#1 chk("irq pin1", 8'h02, {6'h00, pin1, pin2});
		end_sim();
	end
endmodule // test_ffmd_detector
`default_nettype wire
